// file: bench/cpu_model.sv
// processor bus model that feeds the debug trigger unit
module cpu_model (
  // clock
  input wire logic i_clk,
  // monitored buses
  output dbg_trigger_pkg::cpu_bus_s o_bus,
  output dbg_trigger_pkg::cpu_exec_s o_exec
);
  timeunit 1ns;
  timeprecision 1ps;
  dbg_trigger_pkg::cpu_bus_s nb; // queued bus cycle
  dbg_trigger_pkg::cpu_exec_s ne; // queued boundary
  logic pb = 1'b0; // bus cycle pending
  logic pe = 1'b0; // boundary pending
  initial begin
    o_bus = '0;
    o_exec = '0;
  end
  // launch at the edge; idle cycles show a changing pattern
  always @(posedge i_clk) begin
    o_bus <= pb ? nb : {1'b0, ~o_bus.addr, ~o_bus.data, 4'h0};
    o_exec <= pe ? ne : {1'b0, ~o_exec.pc, 1'b0};
    pb = 1'b0;
    pe = 1'b0;
  end
  // one word bus cycle, a single-cycle valid pulse
  task automatic bus(input logic [22:0] a, input logic [15:0] d, input logic rd, input logic fr);
    #1;
    nb = {1'b1, a, d, rd, 1'b1, fr, 1'b0};
    pb = 1'b1;
    @(posedge i_clk);
  endtask
  // one instruction boundary
  task automatic step(input logic [22:0] pc);
    #1;
    ne = {1'b1, pc, 1'b0};
    pe = 1'b1;
    @(posedge i_clk);
  endtask
endmodule

// file: bench/tb.sv
// self-checking bench of the debug trigger unit
`include "dbg_trigger_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] arm_b = 32'h0000_0001 << `DBG_CTL_ARM; // session enable
  localparam logic [31:0] force_trigger_bit_b = 32'h0000_0001 << `DBG_CTL_FORCE_TRIGGER_BIT; // force trigger
  localparam logic [31:0] brk_b = 32'h0000_0001 << `DBG_CTL_BRK_EN; // break enable
  localparam logic [31:0] soft_b = 32'h0000_0001 << `DBG_CTL_BRK_SWI; // break as interrupt
  localparam logic [31:0] trace_b = 32'h0000_0001 << `DBG_CTL_TRACE_EN; // trace enable
  localparam logic [31:0] det_b = 32'(`DBG_TM_DETAIL) << `DBG_CTL_TMODE; // detail trace
  localparam logic [31:0] begin_b = 32'(`DBG_AL_BEGIN) << `DBG_CTL_ALIGN; // trace from trigger
  logic i_clk, i_rst_n, i_secure, i_bdm_enable, awvalid, wvalid, bready, arvalid, rready;
  logic bdm_act, bdm_acc; // background debug activity
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, brk_bdm, brk_swi, armed;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] state;
  dbg_trigger_pkg::cpu_bus_s bus;
  dbg_trigger_pkg::cpu_exec_s ex;
  int failures, checks, nb, ns, fin, b0, s0, f0;
  cpu_model u_cpu (.i_clk(i_clk), .o_bus(bus), .o_exec(ex));
  dbg_trigger #(.DEPTH(8)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .i_exec(ex),
    .i_secure(i_secure), .i_bdm_enable(i_bdm_enable), .i_bdm_active(bdm_act),
    .i_bdm_access(bdm_acc),
    .o_brk_bdm(brk_bdm), .o_brk_swi(brk_swi), .o_armed(armed), .o_state(state),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
  // clock source
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // register write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  // register read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
  endtask
  // count breakpoint pulses and cycles in the final state
  always @(posedge i_clk) begin
    nb += int'(brk_bdm === 1'b1);
    ns += int'(brk_swi === 1'b1);
    fin += int'(state === 3'h4);
  end
  task automatic t_reset;
    logic [31:0] d;
    chk(state, '0);
    rd(`DBG_OFF_CTRL, d);
    chk(d, `DBG_CTRL_RST);
    rd(8'h1C, d);
    chk(resp, `DBG_RESP_SLVERR); // unmapped
    chk(d, '0);
  endtask
  // software trigger: bare break to background, traced break as interrupt
  task automatic t_force;
    logic [31:0] cfg;
    for (int i = 0; i < 2; i++) begin
      cfg = brk_b | (i ? soft_b | trace_b | begin_b : '0);
      b0 = nb;
      s0 = ns;
      f0 = fin;
      wr(`DBG_OFF_CTRL, cfg);
      wr(`DBG_OFF_CTRL, cfg | arm_b);
      chk(state, 1);
      wr(`DBG_OFF_CTRL, cfg | arm_b | force_trigger_bit_b);
      repeat (2) @(posedge i_clk);
      chk(state, 4 * i);
      chk(32'(fin > f0), i);
      chk(nb - b0, 1 - i);
      chk(ns - s0, i);
      chk(armed, i);
      wr(`DBG_OFF_CTRL, cfg);
      chk(armed, 0);
    end
  endtask
  // inside and outside range, read qualified, target final
  task automatic t_cmp;
    wr(`DBG_OFF_CMP_LO, 32'h0000_0100);
    wr(`DBG_OFF_CMP_HI, 32'h0000_01FF);
    for (int m = 1; m < 3; m++) begin
      wr(`DBG_OFF_CMP_CTRL, 32'h0000_0307 | (m << `DBG_CC_MODE));
      wr(`DBG_OFF_CTRL, brk_b | arm_b);
      u_cpu.bus(m == 1 ? 23'h00_01FF : 23'h00_0200, 16'h0000, 1'b0, 1'b0);
      u_cpu.bus(m == 1 ? 23'h00_0200 : 23'h00_0100, 16'h0000, 1'b1, 1'b0);
      @(posedge i_clk);
      {bdm_act, bdm_acc} <= 2'(m); // debug activity hides a hit
      u_cpu.bus(m == 1 ? 23'h00_01FF : 23'h00_0200, 16'h0000, 1'b1, 1'b0);
      u_cpu.step(23'h00_2000);
      {bdm_act, bdm_acc} <= 2'h0;
      repeat (2) @(posedge i_clk);
      chk(state, 1);
      chk(armed, 1);
      b0 = nb;
      u_cpu.bus(m == 1 ? 23'h00_01FF : 23'h00_0200, 16'h0000, 1'b1, 1'b0);
      repeat (2) @(posedge i_clk);
      chk(state, 1);
      u_cpu.step(23'h00_2002);
      repeat (6) @(posedge i_clk);
      chk(armed, 0);
      chk(nb - b0, 1);
    end
  endtask
  // detail trace, open and secured
  task automatic t_trace;
    logic [31:0] d;
    logic [31:0] w_exp [5];
    w_exp = '{32'h0000_0002, 32'h0000_0001, 32'h0000_2345, 32'h0000_BEEF, 32'h0000_0000};
    wr(`DBG_OFF_CMP_CTRL, '0);
    for (int s = 0; s < 2; s++) begin
      i_secure <= s[0];
      wr(`DBG_OFF_CTRL, trace_b | det_b);
      wr(`DBG_OFF_CTRL, trace_b | det_b | arm_b);
      u_cpu.bus(23'h01_2345, 16'hBEEF, 1'b0, 1'b0);
      u_cpu.bus(23'h00_0444, 16'h1111, 1'b1, 1'b1);
      wr(`DBG_OFF_CTRL, trace_b | det_b | arm_b | force_trigger_bit_b);
      u_cpu.step(23'h00_3000);
      repeat (3) @(posedge i_clk);
      chk(armed, 0);
      rd(`DBG_OFF_STATUS, d);
      chk(d[15:8], s ? 0 : 1);
      for (int w = 0; w < 5 && s == 0; w++) begin
        rd(`DBG_OFF_TRACE, d);
        chk(d, w_exp[w]);
      end
    end
  endtask
  initial begin
    #100000;
    failures++;
    print_verdict;
  end
  initial begin
    {i_rst_n, i_secure, awvalid, wvalid, bready, arvalid, rready, bdm_act, bdm_acc} = '0;
    wstrb = 4'hf;
    {awaddr, araddr, wdata} = '0;
    i_bdm_enable = 1'b1;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_force;
    t_cmp;
    t_trace;
    print_verdict;
  end
endmodule

// file: rtl/dbg_trigger.sv
// debug trigger, state sequencer and trace buffer with an AXI4-Lite register slave
// Summary of operation
// (R1) comparator matches advance the state sequencer
// (R2) final state starts tracing and/or breakpoint
// (R3) force_trigger_bit jumps straight to final state
// (R4) trace read through 16-bit register window
// (R5) secured chip: no tracing, breakpoints still work
// (R6) comparators 0,2 match address and masked data
// (R7) comparators 1,3 address plus access size
// (R8) each comparator qualifies by read or write
// (R9) simple, inside-range, outside-range comparator modes
// (R10) tag fires before marked instruction executes
// (R11) forced match acts at next instruction boundary
// (R12) breakpoint enters background debug or software interrupt
// (R13) normal trace stores flow changes only
// (R14) dup_suppress_trace skips repeated source address
// (R15) detail trace stores non-free non-fetch cycles
// (R16) every_address_trace stores every executed address
// (R17) four-stage sequencer; begin, end, mid alignment
// (R18) background debug activity disables all monitoring
// (R19) halt into background debug keeps unit armed
// (R20) arm enters state one; cleared on completion
// (R21) while armed only arm, trigger, bank writable
// (R22) word reads walk trace entries in order
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "dbg_trigger_consts.svh"
module dbg_trigger #(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // monitored processor
  input wire dbg_trigger_pkg::cpu_bus_s i_bus,
  input wire dbg_trigger_pkg::cpu_exec_s i_exec,
  // chip state
  input wire logic i_secure,
  input wire logic i_bdm_enable,
  input wire logic i_bdm_active,
  input wire logic i_bdm_access,
  // breakpoint requests and status
  output logic o_brk_bdm,
  output logic o_brk_swi,
  output logic o_armed,
  output logic [2:0] o_state,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // address match by mode plus direction and size qualifiers
  function automatic logic comp_match(input logic [`DBG_CC_W-1:0] c, input logic [22:0] lo,
                                      input logic [22:0] hi, input logic [22:0] a,
                                      input logic dat_ok, input logic rd, input logic wd,
                                      input logic has_sz);
    logic in_rng;
    logic addr_ok;
    in_rng = (a >= lo) && (a <= hi);
    unique case (c[`DBG_CC_MODE +: 2])
      `DBG_MODE_SIMPLE: addr_ok = (a == lo) && dat_ok; // [R9]
      `DBG_MODE_INSIDE: addr_ok = in_rng; // [R9]
      `DBG_MODE_OUTSIDE: addr_ok = !in_rng; // [R9]
      default: addr_ok = 1'b0; // illegal mode never matches
    endcase
    return addr_ok && (!c[`DBG_CC_RWE] || rd == c[`DBG_CC_RW]) // [R8]
           && (!has_sz || !c[`DBG_CC_SZE] || wd == c[`DBG_CC_SZ]); // [R7]
  endfunction

  // ---------------- state ----------------
  dbg_trigger_pkg::seq_state_e state_q; // sequencer
  logic armed_q; // session enable
  logic [1:0] bank_q, tmode_q, align_q; // software config
  logic brk_en_q, brk_swi_q, trace_en_q;
  logic [`DBG_CC_W-1:0] cc_q [4]; // comparator controls
  logic [22:0] lo_q [4], hi_q [4]; // comparator address / range limits
  logic [15:0] dat_q [2], msk_q [2]; // data compare for comparators 0 and 2
  logic [3:0] pend_q; // forced matches awaiting a boundary
  logic [63:0] tbuf [DEPTH]; // trace entries
  logic [AW-1:0] wptr_q; // next slot
  logic [AW:0] cnt_q, post_q; // stored entries, entries after trigger
  logic [AW+2:0] rd_idx_q; // trace window word index
  logic [22:0] last_pc_q; // previous stored source
  logic have_last_q;
  logic brk_bdm_q, brk_swi_out_q;
  // axi slave state
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // ---------------- decode ----------------
  wire do_wr = aw_got_q && w_got_q && !bvalid_q; // both halves held
  wire ar_hs = i_arvalid && arready_q;
  wire wr_ctrl = do_wr && waddr_q == `DBG_OFF_CTRL && wstrb_q[0];
  wire sw_arm_set = wr_ctrl && wdata_q[`DBG_CTL_ARM] && !armed_q; // [R20]
  wire sw_arm_clr = wr_ctrl && !wdata_q[`DBG_CTL_ARM] && armed_q;
  wire sw_force_trigger_bit = wr_ctrl && wdata_q[`DBG_CTL_FORCE_TRIGGER_BIT] && armed_q; // [R3]
  wire monitor_on = !i_bdm_active && !i_bdm_access; // [R18]
  wire trace_ok = trace_en_q && !i_secure; // [R5]
  wire in_seq = armed_q && state_q != dbg_trigger_pkg::SEQ_IDLE
                && state_q != dbg_trigger_pkg::SEQ_FINAL;
  wire [31:0] ctrl_word = {21'h0, trace_en_q, brk_swi_q, brk_en_q, align_q, tmode_q,
                           bank_q, 1'b0, armed_q};
  wire [31:0] wr_merged_ctrl = merge(ctrl_word, wdata_q, wstrb_q);
  wire [31:0] cmp_word = {22'h0, cc_q[bank_q]};
  wire [31:0] wr_merged_cc = merge(cmp_word, wdata_q, wstrb_q);
  wire [31:0] wr_merged_lo = merge({9'h0, lo_q[bank_q]}, wdata_q, wstrb_q);
  wire [31:0] wr_merged_hi = merge({9'h0, hi_q[bank_q]}, wdata_q, wstrb_q);
  wire [31:0] dat_word = bank_q[0] ? 32'h0000_0000 : {msk_q[bank_q[1]], dat_q[bank_q[1]]};
  wire [31:0] wr_merged_dat = merge(dat_word, wdata_q, wstrb_q);
  wire cfg_wr = do_wr && !armed_q; // [R21]

  // ---------------- comparators ----------------
  logic [3:0] bus_hit, tag_hit, fire;
  // bus and tag matches per comparator
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      bus_hit[k] = monitor_on && cc_q[k][`DBG_CC_EN] && !cc_q[k][`DBG_CC_TAG] && i_bus.valid
                   && comp_match(cc_q[k], lo_q[k], hi_q[k], i_bus.addr, // [R1]
                                 (k % 2 == 1) || (((i_bus.data ^ dat_q[k/2])
                                 & msk_q[k/2]) == 16'h0000), // [R6]
                                 i_bus.read, i_bus.word, k % 2 == 1); // [R7]
      // a tag is matched only as the opcode reaches execute
      tag_hit[k] = monitor_on && cc_q[k][`DBG_CC_EN] && cc_q[k][`DBG_CC_TAG] && i_exec.start
                   && comp_match(cc_q[k], lo_q[k], hi_q[k], i_exec.pc, 1'b1,
                                 cc_q[k][`DBG_CC_RW], 1'b0, 1'b0); // [R10]
      fire[k] = tag_hit[k] || (pend_q[k] && i_exec.start && monitor_on); // [R11]
    end
  end

  // lowest-numbered firing comparator picks the next state
  dbg_trigger_pkg::seq_state_e tgt_state;
  always_comb begin
    tgt_state = dbg_trigger_pkg::SEQ_ONE;
    for (int k = 3; k >= 0; k--) begin
      if (fire[k]) begin
        unique case (cc_q[k][`DBG_CC_TGT +: 2])
          2'h0: tgt_state = dbg_trigger_pkg::SEQ_ONE;
          2'h1: tgt_state = dbg_trigger_pkg::SEQ_TWO;
          2'h2: tgt_state = dbg_trigger_pkg::SEQ_THREE;
          2'h3: tgt_state = dbg_trigger_pkg::SEQ_FINAL;
        endcase
      end
    end
  end
  wire fire_any = in_seq && |fire;
  wire go_final = in_seq && (sw_force_trigger_bit || (fire_any && tgt_state == dbg_trigger_pkg::SEQ_FINAL));
  wire brk_ev = go_final && brk_en_q; // [R2]

  // ---------------- trace source ----------------
  logic rec_ev;
  logic [1:0] rec_kind;
  logic [22:0] rec_addr;
  logic [15:0] rec_data;
  // event choice by trace mode
  always_comb begin
    rec_kind = `DBG_KIND_PC;
    rec_addr = i_exec.pc;
    rec_data = 16'h0000;
    unique case (tmode_q)
      `DBG_TM_NORMAL: rec_ev = i_exec.flow_change_event; // [R13]
      `DBG_TM_DUP: rec_ev = i_exec.flow_change_event && !(have_last_q && i_exec.pc == last_pc_q); // [R14]
      `DBG_TM_DETAIL: begin
        rec_ev = i_bus.valid && !i_bus.free && !i_bus.fetch; // [R15]
        rec_kind = `DBG_KIND_BUS;
        rec_addr = i_bus.addr;
        rec_data = i_bus.data;
      end
      `DBG_TM_EVERY: rec_ev = i_exec.start; // [R16]
    endcase
  end
  // end and mid alignment record from arming, begin alignment from the trigger
  wire rec_on = armed_q && trace_ok && monitor_on && (align_q == `DBG_AL_BEGIN ?
                state_q == dbg_trigger_pkg::SEQ_FINAL :
                state_q != dbg_trigger_pkg::SEQ_IDLE); // [R17]
  wire rec_fire = rec_on && rec_ev;
  // session end: trigger without trace, trigger in end mode, buffer done otherwise
  wire hw_disarm = armed_q && ((go_final && (!trace_ok || align_q == `DBG_AL_END))
                   || (state_q == dbg_trigger_pkg::SEQ_FINAL && rec_fire
                   && ((align_q == `DBG_AL_BEGIN && cnt_q == FULL - 1'b1)
                   || (align_q == `DBG_AL_MID && post_q == HALF - 1'b1)))); // [R20]

  // ---------------- sequencer ----------------
  // halt into background debug does not touch the arm bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= dbg_trigger_pkg::SEQ_IDLE;
      armed_q <= 1'b0;
    end else if (hw_disarm || sw_arm_clr) begin // [R19]
      state_q <= dbg_trigger_pkg::SEQ_IDLE; // hardware disarm beats an arm write
      armed_q <= 1'b0;
    end else if (sw_arm_set) begin
      state_q <= dbg_trigger_pkg::SEQ_ONE; // [R20]
      armed_q <= 1'b1;
    end else if (go_final) begin
      state_q <= dbg_trigger_pkg::SEQ_FINAL; // [R3]
    end else if (fire_any) begin
      state_q <= tgt_state; // [R1]
    end
  end

  // forced matches wait for a boundary; a new match wins over the clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) pend_q <= 4'h0;
    else pend_q <= armed_q ? (bus_hit | (pend_q & {4{!i_exec.start}})) : 4'h0; // [R11]
  end

  // breakpoint requests, background debug only when enabled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      brk_bdm_q <= 1'b0;
      brk_swi_out_q <= 1'b0;
    end else begin
      brk_bdm_q <= brk_ev && !brk_swi_q && i_bdm_enable; // [R12]
      brk_swi_out_q <= brk_ev && (brk_swi_q || !i_bdm_enable); // [R12]
    end
  end

  // ---------------- trace buffer ----------------
  // entry: kind, address, data; no reset on the storage array
  always_ff @(posedge i_clk) begin
    if (rec_fire) tbuf[wptr_q] <= {14'h0, rec_kind, 9'h0, rec_addr, rec_data};
  end
  wire [AW+2:0] words = {cnt_q, 2'b00};
  wire rd_trace = ar_hs && i_araddr == `DBG_OFF_TRACE;
  wire rd_avail = rd_idx_q < words;
  wire [AW-1:0] rd_base = (cnt_q == FULL) ? wptr_q : '0; // oldest entry
  wire [AW-1:0] rd_ent = AW'(rd_base + rd_idx_q[AW+1:2]);
  wire [63:0] rd_line = tbuf[rd_ent];
  wire [15:0] rd_half = rd_line[16*(3 - rd_idx_q[1:0]) +: 16]; // high word first

  // pointers and counts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_q <= '0;
      cnt_q <= '0;
      post_q <= '0;
      rd_idx_q <= '0;
      last_pc_q <= 23'h0;
      have_last_q <= 1'b0;
    end else if (sw_arm_set) begin // new session empties the buffer
      wptr_q <= '0;
      cnt_q <= '0;
      post_q <= '0;
      rd_idx_q <= '0;
      have_last_q <= 1'b0;
    end else begin
      if (rec_fire) begin
        wptr_q <= wptr_q + 1'b1; // wraps for end and mid alignment
        cnt_q <= (cnt_q == FULL) ? cnt_q : cnt_q + 1'b1;
        if (state_q == dbg_trigger_pkg::SEQ_FINAL) post_q <= post_q + 1'b1;
        last_pc_q <= rec_addr; // [R14]
        have_last_q <= 1'b1;
      end
      if (rd_trace && rd_avail) rd_idx_q <= rd_idx_q + 1'b1; // [R22]
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_q <= 2'h0;
      {tmode_q, align_q} <= 4'h0;
      {brk_en_q, brk_swi_q, trace_en_q} <= 3'h0;
    end else if (do_wr && waddr_q == `DBG_OFF_CTRL) begin
      bank_q <= wr_merged_ctrl[`DBG_CTL_BANK +: 2]; // [R21]
      if (!armed_q) begin // [R21]
        tmode_q <= wr_merged_ctrl[`DBG_CTL_TMODE +: 2];
        align_q <= wr_merged_ctrl[`DBG_CTL_ALIGN +: 2];
        brk_en_q <= wr_merged_ctrl[`DBG_CTL_BRK_EN];
        brk_swi_q <= wr_merged_ctrl[`DBG_CTL_BRK_SWI];
        trace_en_q <= wr_merged_ctrl[`DBG_CTL_TRACE_EN];
      end
    end
  end

  // comparator bank reached through the bank select
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 4; k++) begin
        cc_q[k] <= `DBG_CC_W'(`DBG_CMP_RST);
        lo_q[k] <= 23'h0;
        hi_q[k] <= 23'h0;
      end
      dat_q <= '{16'h0000, 16'h0000};
      msk_q <= '{16'h0000, 16'h0000};
    end else if (cfg_wr) begin
      unique case (waddr_q)
        `DBG_OFF_CMP_CTRL: cc_q[bank_q] <= wr_merged_cc[`DBG_CC_W-1:0];
        `DBG_OFF_CMP_LO: lo_q[bank_q] <= wr_merged_lo[22:0];
        `DBG_OFF_CMP_HI: hi_q[bank_q] <= wr_merged_hi[22:0];
        `DBG_OFF_CMP_DATA: begin
          if (!bank_q[0]) begin // [R6]
            dat_q[bank_q[1]] <= wr_merged_dat[15:0];
            msk_q[bank_q[1]] <= wr_merged_dat[31:16];
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------- register read decode ----------------
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (i_araddr)
      `DBG_OFF_CTRL: rd_mux = ctrl_word;
      `DBG_OFF_STATUS: rd_mux = {16'h0, 8'(cnt_q), 4'h0, armed_q, 3'(state_q)};
      `DBG_OFF_TRACE: rd_mux = {16'h0, rd_avail ? rd_half : 16'h0000}; // [R4]
      `DBG_OFF_CMP_CTRL: rd_mux = cmp_word;
      `DBG_OFF_CMP_LO: rd_mux = {9'h0, lo_q[bank_q]};
      `DBG_OFF_CMP_HI: rd_mux = {9'h0, hi_q[bank_q]};
      `DBG_OFF_CMP_DATA: rd_mux = dat_word;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  wire wr_hit = waddr_q inside {`DBG_OFF_CTRL, `DBG_OFF_STATUS, `DBG_OFF_TRACE,
                `DBG_OFF_CMP_CTRL, `DBG_OFF_CMP_LO, `DBG_OFF_CMP_HI, `DBG_OFF_CMP_DATA};

  // ---------------- axi4-lite slave ----------------
  // address and data captured independently, write done when both held
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {aw_got_q, w_got_q, bvalid_q} <= 3'h0;
      {awready_q, wready_q} <= 2'h3;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= `DBG_RESP_OKAY;
    end else begin
      if (i_awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q <= i_awaddr;
      end
      if (i_wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_wr) begin
        {aw_got_q, w_got_q} <= 2'h0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `DBG_RESP_OKAY : `DBG_RESP_SLVERR;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
        {awready_q, wready_q} <= 2'h3;
      end
    end
  end

  // read answered on the same edge that takes the address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `DBG_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `DBG_RESP_OKAY : `DBG_RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // outputs straight from flops
  assign o_brk_bdm = brk_bdm_q;
  assign o_brk_swi = brk_swi_out_q;
  assign o_armed = armed_q;
  assign o_state = state_q;
  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_sw_trigger;
    sw_force_trigger_bit && trace_ok && align_q == `DBG_AL_BEGIN && !hw_disarm;
  endsequence
  sequence s_arm_write;
    sw_arm_set;
  endsequence
  chk_force_trigger_bit_final_state: assert property (s_sw_trigger |=> // [R3]
    state_q == dbg_trigger_pkg::SEQ_FINAL && armed_q) else $error("trigger missed final");
  chk_brk_after_final: assert property (brk_ev |=> (o_brk_bdm ^ o_brk_swi)) // [R2]
    else $error("breakpoint not raised");
  chk_secure_no_trace: assert property (i_secure |-> !rec_fire) // [R5]
    else $error("trace while secured");
  chk_bdm_no_match: assert property (!monitor_on |-> (bus_hit | tag_hit | fire) == 4'h0) // [R18]
    else $error("monitoring during debug");
  chk_force_waits_boundary: assert property (!i_exec.start |-> (fire & ~tag_hit) == 4'h0) // [R11]
    else $error("forced trigger off boundary");
  chk_arm_enters_one: assert property (s_arm_write |=> // [R20]
    state_q == dbg_trigger_pkg::SEQ_ONE && armed_q) else $error("arm did not start");
  chk_no_trace_disarm: assert property (go_final && !trace_ok |=> !armed_q ##1 !armed_q) // [R20]
    else $error("no disarm on bare breakpoint");
  chk_armed_write_lock: assert property (armed_q && do_wr |=> // [R21]
    tmode_q == $past(tmode_q) && cc_q[0] == $past(cc_q[0])) else $error("armed write landed");
  chk_trace_advance: assert property (rd_trace && rd_avail && !sw_arm_set |=> // [R22]
    rd_idx_q == $past(rd_idx_q) + 1'b1) else $error("trace pointer stuck");
  chk_bdm_brk_enabled: assert property (o_brk_bdm |-> $past(i_bdm_enable)) // [R12]
    else $error("background break while disabled");
  chk_halt_stays_armed: assert property (armed_q && i_bdm_active && !do_wr |=> armed_q) // [R19]
    else $error("halt disarmed unit");
endmodule

// file: rtl/dbg_trigger_consts.svh
// register offsets, field positions, encodings and reset values of the debug trigger unit
`ifndef DBG_TRIGGER_CONSTS_SVH
`define DBG_TRIGGER_CONSTS_SVH
// register byte offsets
`define DBG_OFF_CTRL 8'h00
`define DBG_OFF_STATUS 8'h04
`define DBG_OFF_TRACE 8'h08
`define DBG_OFF_CMP_CTRL 8'h0C
`define DBG_OFF_CMP_LO 8'h10
`define DBG_OFF_CMP_HI 8'h14
`define DBG_OFF_CMP_DATA 8'h18
// control register fields
`define DBG_CTL_ARM 0
`define DBG_CTL_FORCE_TRIGGER_BIT 1
`define DBG_CTL_BANK 2
`define DBG_CTL_TMODE 4
`define DBG_CTL_ALIGN 6
`define DBG_CTL_BRK_EN 8
`define DBG_CTL_BRK_SWI 9
`define DBG_CTL_TRACE_EN 10
// comparator control fields
`define DBG_CC_EN 0
`define DBG_CC_RWE 1
`define DBG_CC_RW 2
`define DBG_CC_TAG 3
`define DBG_CC_SZE 4
`define DBG_CC_SZ 5
`define DBG_CC_MODE 6
`define DBG_CC_TGT 8
`define DBG_CC_W 10
// comparator modes
`define DBG_MODE_SIMPLE 2'h0
`define DBG_MODE_INSIDE 2'h1
`define DBG_MODE_OUTSIDE 2'h2
// trace modes
`define DBG_TM_NORMAL 2'h0
`define DBG_TM_DUP 2'h1
`define DBG_TM_DETAIL 2'h2
`define DBG_TM_EVERY 2'h3
// trace alignment to the trigger
`define DBG_AL_END 2'h0
`define DBG_AL_BEGIN 2'h1
`define DBG_AL_MID 2'h2
// trace entry kinds
`define DBG_KIND_PC 2'h1
`define DBG_KIND_BUS 2'h2
// bus answers and reset values
`define DBG_RESP_OKAY 2'h0
`define DBG_RESP_SLVERR 2'h2
`define DBG_CTRL_RST 32'h0000_0000
`define DBG_CMP_RST 32'h0000_0000
`endif

// file: rtl/dbg_trigger_pkg.sv
// types shared by the debug trigger unit
package dbg_trigger_pkg;
  // sequencer states, idle means disarmed
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_ONE, SEQ_TWO, SEQ_THREE, SEQ_FINAL} seq_state_e;
  // one processor data bus cycle
  typedef struct packed {
    logic valid;        // a bus cycle happens now
    logic [22:0] addr;  // full address
    logic [15:0] data;  // data bus
    logic read;         // 1 read, 0 write
    logic word;         // 1 word access, 0 byte
    logic free;         // free cycle
    logic fetch;        // opcode fetch
  } cpu_bus_s;
  // execute stage information
  typedef struct packed {
    logic start;        // an instruction is about to execute (boundary)
    logic [22:0] pc;    // its address
    logic flow_change_event;          // flow_change_event source recorded at pc
  } cpu_exec_s;
endpackage
